// *** logic/dcw_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none
module dcw_decoder
  import dcw_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst_n,
  input  wire logic      rx_valid,
  input  wire dcw_rx_s   rx,
  input  wire dcw_mode_e op_mode,
  input  wire logic [7:0] position_set_selector,
  input  wire logic      set_relative,
  input  wire logic      homing_active,
  input  wire logic      fault_event,
  input  wire logic      fault_cause_present,
  output var  dcw_word_t drive_command_word,
  output var  logic [31:0] target_value,
  output var  logic [3:0] state_cmd,
  output var  logic      state_cmd_stb,
  output var  dcw_pos_s  pos_ctl,
  output var  dcw_spd_s  spd_ctl,
  output var  dcw_word_t status_word,
  output var  logic      fault_active
);

  logic      eval_r;
  dcw_word_t pend_cmd_r;
  logic      ctrl_req_r;
  logic      task_ack_r;
  logic      eval_go;
  logic      is_pos;
  logic      is_spd;
  logic      start_ok;
  dcw_word_t w;
  dcw_word_t rise_w;
  dcw_word_t fall_w;

  // target data lands first, command one cycle later
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      eval_r       <= 1'b0;
      pend_cmd_r   <= CW_RESET;
      target_value <= TARGET_RESET;
    end else begin
      eval_r <= rx_valid;
      if (rx_valid) begin
        target_value <= rx.target;
        pend_cmd_r   <= rx.cmd & CW_USED_MASK;
      end
    end
  end

  always_comb begin
    w        = pend_cmd_r;
    eval_go  = eval_r && w[CW_GATE];
    is_pos   = (op_mode == DCW_MODE_POS);
    is_spd   = (op_mode == DCW_MODE_SPD);
    rise_w   = w & ~drive_command_word;
    fall_w   = ~w & drive_command_word;
    start_ok = eval_go && is_pos && rise_w[CW_SETP] && w[CW_RAMP]
               && w[CW_FREEZE] && !homing_active;
  end

  // held word is the previous evaluated telegram
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drive_command_word <= CW_RESET;
    end else if (eval_go) begin
      drive_command_word <= w;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_cmd     <= '0;
      state_cmd_stb <= 1'b0;
    end else begin
      state_cmd_stb <= eval_go;
      if (eval_go) begin
        state_cmd <= w[CW_ST_MSB:CW_ST_LSB];
      end
    end
  end

  // positioning mode pulses and held relative option
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pos_ctl <= '0;
    end else begin
      pos_ctl.start     <= start_ok;
      pos_ctl.abort_now <= start_ok && w[CW_CHG];
      pos_ctl.append    <= start_ok && !w[CW_CHG];
      pos_ctl.cancel    <= eval_go && is_pos && !w[CW_RAMP];
      pos_ctl.halt      <= eval_go && is_pos && fall_w[CW_SETP];
      if (start_ok) begin
        if (position_set_selector == FIELDBUS_SET_SEL) begin
          pos_ctl.relative <= w[CW_REL];
        end else begin
          pos_ctl.relative <= set_relative;
        end
      end
    end
  end

  // speed mode controls
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      spd_ctl <= '0;
    end else begin
      spd_ctl.accel <= eval_go && is_spd && !w[CW_FREEZE]
                       && rise_w[CW_RAMP];
      spd_ctl.decel <= eval_go && is_spd && !w[CW_FREEZE]
                       && fall_w[CW_RAMP];
      if (eval_go && is_spd) begin
        spd_ctl.frozen  <= w[CW_FREEZE];
        spd_ctl.setp_en <= w[CW_SETP];
        if (!w[CW_FREEZE]) begin
          spd_ctl.ramp_en <= w[CW_RAMP];
        end
      end
    end
  end

  // fault: a new event wins over acknowledge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fault_active <= 1'b0;
    end else if (fault_event) begin
      fault_active <= 1'b1;
    end else if (eval_go && rise_w[CW_FACK] && !fault_cause_present) begin
      fault_active <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_req_r <= 1'b0;
      task_ack_r <= 1'b0;
    end else begin
      if (eval_r) begin
        ctrl_req_r <= w[CW_GATE];
      end
      if (start_ok) begin
        task_ack_r <= ~task_ack_r;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_word <= SW_RESET;
    end else begin
      status_word              <= SW_RESET;
      status_word[SW_FAULT]    <= fault_active;
      status_word[SW_CTRL_REQ] <= ctrl_req_r;
      status_word[SW_TASK_ACK] <= task_ack_r;
    end
  end

  property p_start_timing;
    @(posedge mclk) disable iff (!rst_n)
      pos_ctl.start |-> $past(rx_valid, 2);
  endproperty
  a_start_timing: assert property (p_start_timing)
    else $error("start not two cycles after telegram");

  property p_cancel;
    @(posedge mclk) disable iff (!rst_n)
      (eval_go && is_pos && !w[CW_RAMP]) |=> pos_ctl.cancel;
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("bit4 low did not cancel positioning");

  property p_start_guard;
    @(posedge mclk) disable iff (!rst_n)
      pos_ctl.start |-> $past(!homing_active && w[CW_RAMP]
                              && w[CW_FREEZE] && rise_w[CW_SETP]);
  endproperty
  a_start_guard: assert property (p_start_guard)
    else $error("positioning started without its conditions");

  property p_halt;
    @(posedge mclk) disable iff (!rst_n)
      pos_ctl.halt |-> $past(eval_go && fall_w[CW_SETP]);
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt without bit6 falling edge");

  property p_setp;
    @(posedge mclk) disable iff (!rst_n)
      (eval_go && is_spd) |=> (spd_ctl.setp_en == $past(w[CW_SETP]));
  endproperty
  a_setp: assert property (p_setp)
    else $error("setpoint enable not applied at once");

  property p_gate;
    @(posedge mclk) disable iff (!rst_n)
      (eval_r && !w[CW_GATE]) |=> $stable(drive_command_word)
                                  && !state_cmd_stb;
  endproperty
  a_gate: assert property (p_gate)
    else $error("command word used while gate bit clear");

  property p_fault_set;
    @(posedge mclk) disable iff (!rst_n)
      fault_event |=> fault_active ##1 status_word[SW_FAULT];
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("fault event lost or not reported");

  property p_change;
    @(posedge mclk) disable iff (!rst_n)
      pos_ctl.start |-> (pos_ctl.abort_now == $past(w[CW_CHG]))
                        && (pos_ctl.append != pos_ctl.abort_now);
  endproperty
  a_change: assert property (p_change)
    else $error("abort or append choice wrong");

  property p_reserved;
    @(posedge mclk) disable iff (!rst_n)
      (drive_command_word & ~CW_USED_MASK) == CW_RESET;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits reached the held word");

  property p_freeze;
    @(posedge mclk) disable iff (!rst_n)
      (eval_go && is_spd && w[CW_FREEZE]) |=> $stable(spd_ctl.ramp_en);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("bit4 acted while frozen");

  property p_set_opts;
    @(posedge mclk) disable iff (!rst_n)
      (pos_ctl.start && $past(position_set_selector) != FIELDBUS_SET_SEL)
        |-> (pos_ctl.relative == $past(set_relative));
  endproperty
  a_set_opts: assert property (p_set_opts)
    else $error("relative option not from chosen set");

endmodule
`default_nettype wire

// *** logic/dcw_pkg.sv ***
`default_nettype none
package dcw_pkg;
  localparam int CW_W = 16;
  // command word bit positions
  localparam int CW_ST_LSB = 0;
  localparam int CW_ST_MSB = 3;
  localparam int CW_RAMP   = 4;
  localparam int CW_FREEZE = 5;
  localparam int CW_SETP   = 6;
  localparam int CW_FACK   = 7;
  localparam int CW_GATE   = 10;
  localparam int CW_REL    = 12;
  localparam int CW_CHG    = 13;
  localparam logic [15:0] CW_USED_MASK = 16'h3FFF;
  localparam logic [15:0] CW_RESET     = 16'h0000;
  localparam logic [31:0] TARGET_RESET = 32'h0000_0000;
  // state word bit positions
  localparam int SW_FAULT    = 3;
  localparam int SW_CTRL_REQ = 9;
  localparam int SW_TASK_ACK = 12;
  localparam logic [15:0] SW_RESET = 16'h0000;
  // selector value that picks the fieldbus position set
  localparam logic [7:0] FIELDBUS_SET_SEL = 8'h00;

  typedef logic [15:0] dcw_word_t;

  typedef enum logic {
    DCW_MODE_POS,
    DCW_MODE_SPD
  } dcw_mode_e;

  typedef struct packed {
    logic [15:0] cmd;
    logic [31:0] target;
  } dcw_rx_s;

  typedef struct packed {
    logic start;
    logic abort_now;
    logic append;
    logic relative;
    logic cancel;
    logic halt;
  } dcw_pos_s;

  typedef struct packed {
    logic ramp_en;
    logic frozen;
    logic setp_en;
    logic accel;
    logic decel;
  } dcw_spd_s;
endpackage
`default_nettype wire

// *** verif/dcw_master.sv ***
`timescale 1ns/100ps
`default_nettype none
module dcw_master
  import dcw_pkg::*;
(
  input  wire logic    mclk,
  output var  logic    rx_valid,
  output var  dcw_rx_s rx
);
  initial begin
    rx_valid = 1'b0;
    rx       = '0;
  end
  // one telegram, data released as inverse after the taking edge
  task automatic send(input logic [15:0] cmd, input logic [31:0] tgt);
    @(posedge mclk);
    #1;
    rx_valid = 1'b1;
    rx       = {cmd & CW_USED_MASK, tgt};
    @(posedge mclk);
    #1;
    rx_valid = 1'b0;
    rx       = ~rx;
  endtask
endmodule
`default_nettype wire

// *** verif/dcw_decoder_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module dcw_decoder_tb_top;
  import dcw_pkg::*;
  logic        mclk, rst_n, rx_valid, homing_active, fault_event;
  logic        set_relative, fault_cause_present, stb, fa;
  dcw_rx_s     rx;
  dcw_mode_e   op_mode;
  logic [7:0]  sel;
  dcw_word_t   cw, sw, held;
  logic [31:0] tv;
  logic [3:0]  sc;
  dcw_pos_s    pc;
  dcw_spd_s    spc;
  int          fail_count, n_tests;
  // mode, command, expected pos_ctl or spd_ctl
  logic [24:0] rows [13] = '{
    {1'b0, 16'h0430, 8'h00}, {1'b0, 16'h0477, 8'h28},
    {1'b0, 16'h0430, 8'h01}, {1'b0, 16'h3470, 8'h34},
    {1'b0, 16'h0400, 8'h07}, {1'b0, 16'h0040, 8'h04},
    {1'b0, 16'h0470, 8'h28}, {1'b1, 16'h0400, 8'h01},
    {1'b1, 16'h0470, 8'h0C}, {1'b1, 16'h0450, 8'h14},
    {1'b1, 16'h0410, 8'h10}, {1'b1, 16'h0400, 8'h01},
    {1'b1, 16'h0450, 8'h16}};

  dcw_master m (.mclk(mclk), .rx_valid(rx_valid), .rx(rx));
  dcw_decoder uut (.mclk(mclk), .rst_n(rst_n), .rx_valid(rx_valid),
    .rx(rx), .op_mode(op_mode), .position_set_selector(sel),
    .set_relative(set_relative), .homing_active(homing_active),
    .fault_event(fault_event), .fault_cause_present(fault_cause_present),
    .drive_command_word(cw), .target_value(tv), .state_cmd(sc),
    .state_cmd_stb(stb), .pos_ctl(pc), .spd_ctl(spc), .status_word(sw),
    .fault_active(fa));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // telegram, then stop in the one cycle the evaluated pulses stand
  task automatic tel(input logic [15:0] c, input logic [31:0] t);
    m.send(c, t);
    @(posedge mclk);
    #1;
    chk(tv, t);
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    wrap_up;
  end

  initial begin
    rst_n = 1'b0;
    op_mode = DCW_MODE_POS;
    sel = FIELDBUS_SET_SEL;
    set_relative = 1'b0;
    homing_active = 1'b0;
    fault_event = 1'b0;
    fault_cause_present = 1'b0;
    fail_count = 0;
    n_tests = 0;
    held = '0;
    repeat (10) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    chk({cw, sw}, 32'h0000_0000);
    chk({pc, spc, stb, fa}, 32'h0000_0000);
    foreach (rows[i]) begin
      op_mode = dcw_mode_e'(rows[i][24]);
      tel(rows[i][23:8], 32'hA500_0000 + 32'(i));
      if (rows[i][18]) begin
        held = rows[i][23:8];
      end
      chk(cw, held);
      chk(stb, rows[i][18]);
      chk(sc, held[3:0]);
      if (rows[i][24]) begin
        chk(spc, rows[i][4:0]);
      end else begin
        chk(pc, rows[i][5:0]);
      end
    end
    // status word lags the evaluated outputs by one cycle
    @(posedge mclk);
    #1;
    chk(sw, 16'h1200);
    op_mode = DCW_MODE_POS;
    homing_active = 1'b1;
    tel(16'h0400, 32'h0000_0001);
    tel(16'h0470, 32'h0000_0002);
    chk(pc.start, 1'b0);
    homing_active = 1'b0;
    sel = 8'h01;
    set_relative = 1'b1;
    tel(16'h0400, 32'h0000_0003);
    tel(16'h2470, 32'h0000_0004);
    chk({pc.start, pc.abort_now, pc.relative}, 3'h7);
    fault_event = 1'b1;
    fault_cause_present = 1'b1;
    @(posedge mclk);
    #1;
    fault_event = 1'b0;
    chk(fa, 1'b1);
    tel(16'h0480, 32'h0000_0005);
    chk(fa, 1'b1);
    chk(sw[SW_FAULT], 1'b1);
    fault_cause_present = 1'b0;
    tel(16'h0400, 32'h0000_0006);
    tel(16'h0480, 32'h0000_0007);
    chk(fa, 1'b0);
    // new fault in the same cycle as an acknowledge: set wins
    tel(16'h0400, 32'h0000_0008);
    fault_event = 1'b1;
    tel(16'h0480, 32'h0000_0009);
    chk(fa, 1'b1);
    fault_event = 1'b0;
    // reset in mid-run clears everything at once
    rst_n = 1'b0;
    #1;
    chk({cw, sw}, 32'h0000_0000);
    chk({pc, spc, stb, fa}, 32'h0000_0000);
    @(posedge mclk);
    #1;
    rst_n = 1'b1;
    tel(16'h0470, 32'h0000_000A);
    chk({pc.start, pc.append}, 2'h3);
    wrap_up;
  end
endmodule
`default_nettype wire
